// [include/sfp_ctrl_pkg.sv]
// constants shared by the transceiver control ends and their link
// assumes a 100 MHz clk_i on both ends and a 2-wire bus with pull-ups
//
// Behaviour
// RULE1: pin off request kills light within 10 us
// RULE2: pin release restores light within 1 ms
// RULE3: initialise within 300 ms, fault cleared
// RULE4: fault flag pin asserts within 1000 us
// RULE5: off request held 10 us clears fault
// RULE6: signal lost pin asserts within 100 us
// RULE7: signal lost pin drops within 100 us
// RULE8: soft off bit kills light within 100 ms
// RULE9: soft off cleared restores light within 100 ms
// RULE10: fault status bit sets within 100 ms
// RULE11: lost status bit follows signal within 100 ms
// RULE12: data ready bit asserts within 1000 ms
// RULE13: bus usable by 300 ms; host waits
// RULE14: host leaves 20 us between stop and start
// RULE15: internal write done within 40/80 ms
// RULE16: host serial clock at most 400 kHz
// RULE17: pin or soft bit turns light off
package sfp_ctrl_pkg;

  // clock
  localparam int unsigned CLK_MHZ = 100;

  // timing figures in their own units
  localparam int unsigned T_RESET_US  = 10;
  localparam int unsigned T_SERIAL_MS = 300;
  localparam int unsigned T_BUF_US    = 20;
  localparam int unsigned SCL_MAX_KHZ = 400;
  localparam int unsigned SETTLE_US   = 20;

  // derived cycle counts
  localparam int unsigned T_RESET_CYC  = T_RESET_US * CLK_MHZ;
  localparam int unsigned T_SERIAL_CYC = T_SERIAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned T_BUF_CYC    = T_BUF_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  // quarter bit time, rounded up so the clock never runs fast
  localparam int unsigned SCL_Q_CYC =
    (CLK_MHZ * 1000 + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);

  // bus addresses (7 bit) of the two pages
  localparam logic [6:0] ID_ADDR   = 7'h50;
  localparam logic [6:0] DIAG_ADDR = 7'h51;

  // control/status byte of the diagnostic page
  localparam logic [7:0] CSB_OFS      = 8'h6e;
  localparam logic [7:0] CSB_RESET    = 8'h00;
  localparam int unsigned PIN_OFF_BIT = 7;
  localparam int unsigned SOFT_OFF_BIT = 6;
  localparam int unsigned FAULT_BIT   = 2;
  localparam int unsigned LOS_BIT     = 1;
  localparam int unsigned READY_BIT   = 0;

  // host controller apb map
  localparam logic [7:0] HREG_CMD    = 8'h00;
  localparam logic [7:0] HREG_TARGET = 8'h04;
  localparam logic [7:0] HREG_WDATA  = 8'h08;
  localparam logic [7:0] HREG_STATUS = 8'h0c;
  localparam logic [7:0] HREG_PINS   = 8'h10;
  localparam int unsigned CMD_WR_BIT   = 0;
  localparam int unsigned CMD_RD_BIT   = 1;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_NACK_BIT  = 1;
  localparam int unsigned ST_READY_BIT = 2;
  localparam int unsigned ST_RDATA_POS = 8;
  localparam int unsigned ST_FAULT_BIT = 16;
  localparam int unsigned ST_LOS_BIT   = 17;
  localparam int unsigned TGT_REG_POS  = 8;

endpackage

// [include/sfp_link_if.sv]
// pins between host board controller and the transceiver end
// assumes external pull-ups on both bus lines
`timescale 1ns/1ps
interface sfp_link_if;
  logic laser_off_request;
  logic laser_fault_flag;
  logic rx_signal_lost;
  logic scl_host_o;
  logic scl_host_oen;
  logic sda_host_o;
  logic sda_host_oen;
  logic sda_dev_o;
  logic sda_dev_oen;
  wire  scl;
  wire  sda;

  // open-drain wired and, released lines float high
  assign scl = scl_host_oen | scl_host_o;
  assign sda = (sda_host_oen | sda_host_o) & (sda_dev_oen | sda_dev_o);

  modport dev (
    input  laser_off_request, scl, sda,
    output laser_fault_flag, rx_signal_lost, sda_dev_o, sda_dev_oen
  );

  modport host (
    output laser_off_request, scl_host_o, scl_host_oen,
    output sda_host_o, sda_host_oen,
    input  laser_fault_flag, rx_signal_lost, scl, sda
  );
endinterface

// [rtl/pin_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
// assumes inputs are independent levels, no bus coherence needed
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// [rtl/sfp_dev_end.sv]
// transceiver end: laser control, fault latch, loss of signal and
// the control/status byte behind a 2-wire target
// assumes host keeps bus clock slow (far below clk_i) and bus free time
//
`timescale 1ns/1ps
module sfp_dev_end
  import sfp_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // link to the host board
  sfp_link_if.dev   link,
  // optics side
  input  wire logic laser_fault_i,
  input  wire logic signal_valid_i,
  output logic      laser_on_o,
  output logic      data_ready_o
);
  import sfp_ctrl_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX   = 5'b00010,
    S_ACK  = 5'b00100,
    S_TX   = 5'b01000,
    S_RACK = 5'b10000
  } tgt_state_t;

  localparam int unsigned SW = $clog2(SETTLE_CYC + 1);
  localparam int unsigned HW = $clog2(T_RESET_CYC + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC - 1);
  localparam logic [HW-1:0] HOLD_LAST   = HW'(T_RESET_CYC - 1);

  logic [4:0]  raw;
  logic [4:0]  syn;
  wire         off_pin;
  wire         scl;
  wire         sda;
  wire         fault_in;
  wire         sig_ok;
  logic        scl_q;
  logic        sda_q;
  logic [SW-1:0] settle_cnt;
  logic        ready;
  logic [HW-1:0] hold_cnt;
  wire         fault_clear;
  logic        fault_q;
  logic        los_q;
  logic        soft_off;
  wire         eff_off;
  wire  [7:0]  csb;
  tgt_state_t  st;
  logic [3:0]  bit_cnt;
  logic [7:0]  sh;
  logic [1:0]  byte_no;
  logic        rd_mode;
  logic        diag_sel;
  logic [7:0]  ptr;
  logic        sda_low;
  wire         scl_rise;
  wire         scl_fall;
  wire         start_seen;
  wire         stop_seen;
  wire         byte_done;
  wire         addr_hit;
  wire  [7:0]  rd_byte;
  wire         csb_write;

  // every outside level is synchronised before use
  assign raw = {link.laser_off_request, link.scl, link.sda,
                laser_fault_i, signal_valid_i};

  pin_sync #(.W(5)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (raw),
    .q_o    (syn)
  );

  assign off_pin  = syn[4];
  assign scl      = syn[3];
  assign sda      = syn[2];
  assign fault_in = syn[1];
  assign sig_ok   = syn[0];

  // previous bus levels for edge and condition detection
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // power-on settle; laser drive and bus come alive together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_cnt <= '0;
      ready      <= 1'b0;
    end else if (!ready) begin
      settle_cnt <= settle_cnt + SW'(1);
      ready      <= (settle_cnt == SETTLE_LAST); // RULE12 RULE13 RULE3
    end
  end

  // length of the current off request, saturating
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_cnt <= '0;
    end else if (!off_pin) begin
      hold_cnt <= '0;
    end else if (hold_cnt != HW'(T_RESET_CYC)) begin
      hold_cnt <= hold_cnt + HW'(1);
    end
  end

  // one pulse once the request has been high long enough
  assign fault_clear = off_pin && (hold_cnt == HOLD_LAST); // RULE5

  // fault latch; a new fault wins over the clearing pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_q <= 1'b0;
    end else if (fault_in) begin
      fault_q <= 1'b1; // RULE4 RULE10
    end else if (fault_clear) begin
      fault_q <= 1'b0; // RULE3
    end
  end

  // receiver loss follows the detector directly
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      los_q <= 1'b1;
    end else begin
      los_q <= !sig_ok; // RULE6 RULE7 RULE11
    end
  end

  // either source of off request disables the light
  assign eff_off = off_pin | soft_off; // RULE17

  // laser drive: off at once, back on as soon as allowed
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      laser_on_o <= 1'b0;
    end else begin
      laser_on_o <= ready & !eff_off & !fault_q; // RULE1 RULE2 RULE8 RULE9
    end
  end

  // pins and the ready flag toward the user
  assign link.laser_fault_flag = fault_q; // RULE4
  assign link.rx_signal_lost   = los_q;   // RULE6 RULE7
  assign data_ready_o          = ready;

  // control/status byte as software reads it
  assign csb = {off_pin, soft_off, 3'b000, fault_q, los_q,
                ready}; // RULE10 RULE11 RULE12

  // bus conditions, sampled on synchronised levels
  assign scl_rise   = scl & !scl_q;
  assign scl_fall   = !scl & scl_q;
  assign start_seen = ready & scl & scl_q & sda_q & !sda; // RULE13
  assign stop_seen  = scl & scl_q & !sda_q & sda;
  assign byte_done  = (st == S_RX) && scl_fall && (bit_cnt == 4'h8);
  assign addr_hit   = ready &&
                      ((sh[7:1] == ID_ADDR) || (sh[7:1] == DIAG_ADDR));

  // only the diagnostic page holds live data; id page reads zero
  assign rd_byte   = (diag_sel && ptr == CSB_OFS) ? csb : 8'h00;
  assign csb_write = byte_done && (byte_no == 2'd2) && diag_sel &&
                     (ptr == CSB_OFS);

  // soft off takes effect on the data byte itself, long before stop
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_off <= CSB_RESET[SOFT_OFF_BIT];
    end else if (csb_write) begin
      soft_off <= sh[SOFT_OFF_BIT]; // RULE8 RULE9 RULE15
    end
  end

  // target sequencer; writes land at once, so never busy after stop
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st       <= S_IDLE;
      bit_cnt  <= 4'h0;
      sh       <= 8'h00;
      byte_no  <= 2'd0;
      rd_mode  <= 1'b0;
      diag_sel <= 1'b0;
      ptr      <= 8'h00;
      sda_low  <= 1'b0;
    end else if (stop_seen) begin
      st      <= S_IDLE;
      sda_low <= 1'b0;
    end else if (start_seen) begin
      st      <= S_RX;
      bit_cnt <= 4'h0;
      byte_no <= 2'd0;
      sda_low <= 1'b0;
    end else begin
      case (st)
        S_RX: begin
          if (scl_rise) begin
            sh      <= {sh[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (byte_no == 2'd0 && !addr_hit) begin
              st <= S_IDLE;
            end else begin
              st      <= S_ACK;
              sda_low <= 1'b1;
            end
            if (byte_no == 2'd0) begin
              rd_mode  <= sh[0];
              diag_sel <= (sh[7:1] == DIAG_ADDR);
            end
            if (byte_no == 2'd1) begin
              ptr <= sh;
            end
            if (byte_no == 2'd2) begin
              ptr <= ptr + 8'h01;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (byte_no != 2'd2) begin
              byte_no <= byte_no + 2'd1;
            end
            if (rd_mode && byte_no == 2'd0) begin
              st      <= S_TX;
              sh      <= rd_byte;
              sda_low <= !rd_byte[7];
            end else begin
              st      <= S_RX;
              sda_low <= 1'b0;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              st      <= S_RACK;
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              ptr     <= ptr + 8'h01;
            end else begin
              sh      <= {sh[6:0], 1'b0};
              sda_low <= !sh[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          // a not-acknowledge from the host ends the read
          if (scl_rise && sda) begin
            st <= S_IDLE;
          end else if (scl_fall) begin
            st      <= S_TX;
            sh      <= rd_byte;
            sda_low <= !rd_byte[7];
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // open-drain data line, enable low while pulling low
  assign link.sda_dev_o   = 1'b0;
  assign link.sda_dev_oen = !sda_low;

endmodule

// [rtl/sfp_host_end.sv]
// host board controller: apb registers, pin control and a 2-wire
// initiator for single-byte writes and reads of the transceiver
// assumes the target never stretches the bus clock
`timescale 1ns/1ps
module sfp_host_end
  import sfp_ctrl_pkg::*;
#(
  parameter int unsigned POR_WAIT_CYC = sfp_ctrl_pkg::T_SERIAL_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // link to the transceiver
  sfp_link_if.host         link
);
  import sfp_ctrl_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_GAP   = 5'b00010,
    M_START = 5'b00100,
    M_BIT   = 5'b01000,
    M_STOP  = 5'b10000
  } ini_state_t;

  localparam int unsigned QW = $clog2(SCL_Q_CYC);
  localparam int unsigned GW = $clog2(T_BUF_CYC + 1);

  logic [2:0]  syn;
  ini_state_t  st;
  logic [31:0] por_cnt;
  logic        bus_ready;
  logic [QW-1:0] div;
  logic [GW-1:0] gap_cnt;
  logic [1:0]  q;
  logic [3:0]  bit_cnt;
  logic [1:0]  k;
  logic        op_rd;
  logic        pass2;
  logic [7:0]  sh;
  logic [7:0]  rdata;
  logic        nack;
  logic        scl_low;
  logic        sda_low;
  logic [6:0]  dev_addr;
  logic [7:0]  reg_ofs;
  logic [7:0]  wdata;
  logic        off_req;
  wire         tick;
  wire         wr_acc;
  wire         go_wr;
  wire         go_rd;
  wire         rx_byte;
  wire         last_byte;
  wire         hit;
  wire  [31:0] status;

  // byte sent at position n of the current pass
  function automatic logic [7:0] tx_byte(input logic [1:0] n);
    if (n == 2'd0) begin
      tx_byte = {dev_addr, pass2};
    end else if (n == 2'd1) begin
      tx_byte = reg_ofs;
    end else begin
      tx_byte = wdata;
    end
  endfunction

  pin_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({link.laser_fault_flag, link.rx_signal_lost, link.sda}),
    .q_o    (syn)
  );

  // apb decode; always ready, unmapped addresses error
  assign pready_o  = 1'b1;
  assign wr_acc    = psel_i & penable_i & pwrite_i;
  assign hit       = (paddr_i == HREG_CMD) || (paddr_i == HREG_TARGET) ||
                     (paddr_i == HREG_WDATA) ||
                     (paddr_i == HREG_STATUS) || (paddr_i == HREG_PINS);
  assign pslverr_o = psel_i & penable_i & !hit;
  // commands while busy or before the bus is up are dropped
  assign go_wr = wr_acc && (paddr_i == HREG_CMD) && pwdata_i[CMD_WR_BIT]
                 && bus_ready && (st == M_IDLE); // RULE13
  assign go_rd = wr_acc && (paddr_i == HREG_CMD) && pwdata_i[CMD_RD_BIT]
                 && !pwdata_i[CMD_WR_BIT] && bus_ready && (st == M_IDLE);

  assign status = {14'h0000, syn[1], syn[2], rdata, 5'h00, bus_ready,
                   nack, (st != M_IDLE)};

  // read mux, unmapped and command read as zero
  always_comb begin
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      HREG_TARGET: prdata_o = {16'h0000, reg_ofs, 1'b0, dev_addr};
      HREG_WDATA:  prdata_o = {24'h000000, wdata};
      HREG_STATUS: prdata_o = status;
      HREG_PINS:   prdata_o = {31'h0000_0000, off_req};
      default:     prdata_o = 32'h0000_0000;
    endcase
  end

  // software registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_addr <= 7'h00;
      reg_ofs  <= 8'h00;
      wdata    <= 8'h00;
      off_req  <= 1'b0;
    end else if (wr_acc) begin
      if (paddr_i == HREG_TARGET) begin
        dev_addr <= pwdata_i[6:0];
        reg_ofs  <= pwdata_i[TGT_REG_POS +: 8];
      end
      if (paddr_i == HREG_WDATA) begin
        wdata <= pwdata_i[7:0];
      end
      if (paddr_i == HREG_PINS) begin
        off_req <= pwdata_i[0]; // RULE5
      end
    end
  end

  // power-on wait before the bus may be used
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_cnt   <= 32'h0000_0000;
      bus_ready <= 1'b0;
    end else if (!bus_ready) begin
      por_cnt   <= por_cnt + 32'h0000_0001;
      bus_ready <= (por_cnt == 32'(POR_WAIT_CYC - 1)); // RULE13
    end
  end

  // quarter-bit enable keeps the bus clock under its limit
  assign tick = (div == QW'(SCL_Q_CYC - 1)); // RULE16
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div <= '0;
    end else begin
      div <= tick ? '0 : div + QW'(1);
    end
  end

  assign rx_byte   = pass2 && (k == 2'd1);
  assign last_byte = op_rd ? (k == 2'd1) : (k == 2'd2);

  // initiator sequencer, one quarter phase per tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= M_IDLE;
      gap_cnt <= '0;
      q <= 2'd0;
      bit_cnt <= 4'h0;
      k <= 2'd0;
      op_rd <= 1'b0;
      pass2 <= 1'b0;
      sh <= 8'h00;
      rdata <= 8'h00;
      nack <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      case (st)
        M_IDLE: begin
          if (go_wr || go_rd) begin
            st <= M_GAP;
            op_rd <= go_rd;
            pass2 <= 1'b0;
            nack <= 1'b0;
            gap_cnt <= '0;
          end
        end
        M_GAP: begin
          gap_cnt <= gap_cnt + GW'(1);
          if (gap_cnt == GW'(T_BUF_CYC)) begin
            st <= M_START; // RULE14
            q <= 2'd0;
            k <= 2'd0;
          end
        end
        M_START: begin
          if (tick) begin
            q <= q + 2'd1;
            if (q == 2'd2) sda_low <= 1'b1;
            if (q == 2'd3) begin
              scl_low <= 1'b1;
              st <= M_BIT;
              bit_cnt <= 4'h0;
              sh <= tx_byte(2'd0);
            end
          end
        end
        M_BIT: begin
          if (tick) begin
            q <= q + 2'd1;
            if (q == 2'd0) begin
              sda_low <= (bit_cnt < 4'h8) && !rx_byte && !sh[7];
            end
            if (q == 2'd1) scl_low <= 1'b0;
            if (q == 2'd2) begin
              if (bit_cnt < 4'h8 && rx_byte) rdata <= {rdata[6:0], syn[0]};
              if (bit_cnt == 4'h8 && !rx_byte && syn[0]) nack <= 1'b1;
            end
            if (q == 2'd3) begin
              scl_low <= 1'b1;
              if (bit_cnt != 4'h8) begin
                bit_cnt <= bit_cnt + 4'h1;
                sh <= {sh[6:0], 1'b0};
              end else if (nack || last_byte) begin
                st <= M_STOP;
              end else begin
                bit_cnt <= 4'h0;
                k <= k + 2'd1;
                sh <= tx_byte(k + 2'd1);
              end
            end
          end
        end
        M_STOP: begin
          if (tick) begin
            q <= q + 2'd1;
            if (q == 2'd0) sda_low <= 1'b1;
            if (q == 2'd1) scl_low <= 1'b0;
            if (q == 2'd2) sda_low <= 1'b0;
            if (q == 2'd3) begin
              // a read repeats with the direction bit set
              if (op_rd && !pass2 && !nack) begin
                pass2 <= 1'b1;
                st <= M_GAP;
                gap_cnt <= '0;
              end else begin
                st <= M_IDLE;
              end
            end
          end
        end
        default: st <= M_IDLE;
      endcase
    end
  end

  // pins; bus enables low while pulling the line low
  assign link.laser_off_request = off_req;
  assign link.scl_host_o   = 1'b0;
  assign link.scl_host_oen = !scl_low;
  assign link.sda_host_o   = 1'b0;
  assign link.sda_host_oen = !sda_low;

endmodule

// [test/sfp_link_monitor.sv]
// assertions on the link between host controller and transceiver end
// assumes both ends share the 100 MHz clk_i and rstn_i of the bench
`timescale 1ns/1ps
module sfp_link_monitor
  import sfp_ctrl_pkg::*;
#(
  parameter int unsigned POR_WAIT_CYC = 3000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link signals
  input wire logic laser_off_request,
  input wire logic laser_fault_flag,
  input wire logic sda_dev_oen,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [31:0] por_cnt, gap_cnt, per_cnt, off_cnt;
  logic        scl_q, sda_q, off_q;
  // start and stop seen on registered copies, no sampled functions here
  wire start_w = scl & scl_q & sda_q & !sda;
  wire stop_w  = scl & scl_q & !sda_q & sda;

  // cycles since reset, stop, scl rise; off request run length
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {scl_q, sda_q, off_q} <= 3'h6;
      {por_cnt, gap_cnt, per_cnt, off_cnt} <= '0;
    end else begin
      {scl_q, sda_q, off_q} <= {scl, sda, laser_off_request};
      por_cnt <= por_cnt + 32'h1;
      gap_cnt <= stop_w ? 32'h0 : gap_cnt + 32'h1;
      per_cnt <= (scl & !scl_q) ? 32'h1 : per_cnt + 32'h1;
      off_cnt <= (laser_off_request & !off_q) ? 32'h1 :
                 off_cnt + 32'(laser_off_request);
    end
  end

  a_fault_clear_pulse: assert property (
    $fell(laser_fault_flag) |-> off_cnt >= T_RESET_CYC)
    else $error("fault flag cleared by a short off pulse");
  a_fault_stays_latched: assert property (
    laser_fault_flag && !laser_off_request |=> laser_fault_flag)
    else $error("fault flag dropped without off request");
  a_bus_ready_wait: assert property (
    start_w |-> por_cnt >= POR_WAIT_CYC)
    else $error("start before bus ready time");
  a_dev_quiet_early: assert property (
    !sda_dev_oen |-> por_cnt >= SETTLE_CYC)
    else $error("device drove sda before ready");
  a_stop_start_gap: assert property (
    start_w |-> gap_cnt >= T_BUF_CYC)
    else $error("bus free time too short");
  a_scl_period_min: assert property (
    $rose(scl) |-> per_cnt >= 250)
    else $error("scl faster than allowed");
  a_scl_low_min: assert property (
    $fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  a_dev_sda_scl_low: assert property (
    $changed(sda_dev_oen) |-> !scl)
    else $error("device changed sda while scl high");

  c_start: cover property (start_w);
  c_stop: cover property (stop_w);
  c_fault_clear: cover property ($fell(laser_fault_flag));
endmodule

// [test/tb_transceiver_ctrl_status_timing.sv]
// bench joining host controller and transceiver end over their link
// apb wait states met by polling pready; bus transfers polled through status
`timescale 1ns/1ps
module tb_transceiver_ctrl_status_timing;
  import sfp_ctrl_pkg::*;
  localparam int unsigned POR = 3000; // shortened bus ready wait
  logic        clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic        fault_i = 0, valid_i = 1, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, laser_on, ready;
  int          n_mismatch = 0, checks_done = 0;
  sfp_link_if link ();
  wire  [3:0]  pins = {link.rx_signal_lost, link.laser_fault_flag, ready,
                       laser_on};

  sfp_host_end #(.POR_WAIT_CYC(POR)) sfp_host_end_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link(link));
  sfp_dev_end sfp_dev_end_i (.clk_i(clk_i), .rstn_i(rstn_i), .link(link),
    .laser_fault_i(fault_i), .signal_valid_i(valid_i),
    .laser_on_o(laser_on), .data_ready_o(ready));
  sfp_link_monitor #(.POR_WAIT_CYC(POR)) sfp_link_monitor_i (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .laser_off_request(link.laser_off_request),
    .laser_fault_flag(link.laser_fault_flag),
    .sda_dev_oen(link.sda_dev_oen), .scl(link.scl), .sda(link.sda));

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; a trailing idle edge keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i) penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stuck access
    do begin @(posedge clk_i); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  // single byte at the control/status offset, then poll until idle
  task automatic bus(input logic [6:0] dev, input logic rdn,
                     input logic [7:0] d);
    apb(1, HREG_TARGET, {16'h0, CSB_OFS, 1'b0, dev});
    apb(1, HREG_WDATA, {24'h0, d});
    apb(1, HREG_CMD, rdn ? 2 : 1);
    do begin apb(0, HREG_STATUS, 0); end
    while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask

  // bounded wait; the bound is never above the allowed response time
  task automatic wait_pin(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (pins[sel] !== v && n < lim) begin @(posedge clk_i); n++; end
    chk(pins[sel], v);
  endtask

  function automatic logic [7:0] csb(input logic s, f, l);
    csb = {1'b0, s, 3'b000, f, l, 1'b1};
  endfunction

  initial forever #5 clk_i = ~clk_i;

  // watchdog beyond the expected run of about 0.75 ms, under 100k cycles
  initial begin
    #900_000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    logic [7:0] d;
    int k;
    void'($urandom(54261));
    repeat (5) @(posedge clk_i);
    chk(pins, 4'b1000);
    rstn_i <= 1'b1;
    wait_pin(1, 1, 2100);
    wait_pin(0, 1, 10);
    apb(0, 8'h40, 0);
    chk({err, rd[30:0]}, 0 | 1 << 31);
    apb(1, HREG_PINS, 1);
    wait_pin(0, 0, T_RESET_CYC);
    apb(1, HREG_PINS, 0);
    wait_pin(0, 1, 100000);
    fault_i <= 1'b1;
    wait_pin(2, 1, 100000);
    fault_i <= 1'b0;
    k = 10 + $urandom % 900;
    apb(1, HREG_PINS, 1);
    repeat (k) @(posedge clk_i);
    apb(1, HREG_PINS, 0);
    repeat (20) @(posedge clk_i);
    chk(link.laser_fault_flag, 1);
    repeat (POR) @(posedge clk_i);
    apb(0, HREG_STATUS, 0);
    chk(rd[ST_READY_BIT], 1);
    bus(DIAG_ADDR, 1, 0);
    chk(rd[15:8], csb(0, 1, 0));
    chk(rd[ST_FAULT_BIT +: 2], 2'b01);
    apb(1, HREG_PINS, 1);
    wait_pin(2, 0, T_RESET_CYC + 100);
    apb(1, HREG_PINS, 0);
    wait_pin(0, 1, 100000);
    valid_i <= 1'b0;
    wait_pin(3, 1, 10000);
    d = $urandom;
    bus(DIAG_ADDR, 0, d | 8'h40);
    chk(rd[ST_NACK_BIT], 0);
    wait_pin(0, 0, 1000000);
    bus(DIAG_ADDR, 1, 0);
    chk(rd[15:8], csb(1, 0, 1));
    valid_i <= 1'b1;
    wait_pin(3, 0, 10000);
    bus(DIAG_ADDR, 0, d & 8'hbf);
    wait_pin(0, 1, 1000000);
    bus(7'h33, 0, d);
    chk(rd[ST_NACK_BIT], 1);
    // id page acknowledges and reads as zero
    bus(ID_ADDR, 1, 0);
    chk(rd[15:1], 15'h0002);
    stop_test();
  end
endmodule
